// ===== kms_keypad_model.sv
// Switch matrix model: 5 columns by 6 rows, one switch at each crossing.
// Assumes active low column drive and pull-ups on every row.
module kms_keypad_model (
  // Matrix pins
  input  wire logic [4:0]  col_out,
  output logic [5:0]       row_in,
  // Closed switches, bit c*6+r joins column c to row r
  input  wire logic [29:0] keys_down
);
  // Released rows float up to the pull-up level
  always_comb
  begin
    row_in = 6'h3f;
    for (int c = 0; c < 5; c++)
      for (int r = 0; r < 6; r++)
        if (keys_down[c*6+r] && !col_out[c])
          row_in[r] = 1'b0;
  end
endmodule // kms_keypad_model

// ===== kms_pkg.sv
// Constants, register map and bus carrier of the keypad matrix scanner.
// Assumes one 50 MHz clock and an 8-bit register port.
package kms_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] KMS_ADR_DRIVE   = 8'hd1;
  localparam logic [7:0] KMS_ADR_SENSE   = 8'hd2;
  localparam logic [7:0] KMS_ADR_TIMING  = 8'hd3;
  localparam logic [7:0] KMS_ADR_CTRL    = 8'hd4;
  localparam logic [7:0] KMS_ADR_INT_ST  = 8'hd8;
  localparam logic [7:0] KMS_ADR_INT_CLR = 8'hd9;
  localparam logic [7:0] KMS_ADR_INT_EN  = 8'hda;

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [4:0] KMS_DRIVE_RST  = 5'h1f;
  localparam logic [5:0] KMS_SENSE_RST  = 6'h3f;
  localparam logic [7:0] KMS_TIMING_RST = 8'h00;
  localparam int KMS_SETTLE_LSB = 2;
  localparam int KMS_PROBE_LSB  = 0;
  localparam int KMS_CTL_EN     = 0;
  localparam int KMS_CTL_FLAG   = 1;
  localparam int KMS_CTL_AUTO   = 2;
  localparam int KMS_CTL_CLK    = 3;
  localparam int KMS_INT_KEY    = 0;
  localparam int KMS_INT_MULTI  = 1;
  localparam int KMS_COLS       = 5;
  localparam int KMS_ROWS       = 6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int KMS_CLK_NS      = 20;
  localparam int KMS_TICK_NS     = 1000000;
  localparam int KMS_TICK_CYCLES = KMS_TICK_NS / KMS_CLK_NS;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } kms_bus_req_type;

endpackage

// ===== kms_scanner.sv
// Keypad matrix scanner: register port, 1 kHz tick, sweep engine.
// Assumes row pins are asynchronous with pull-ups; columns drive the matrix.
//
// The strobed register port was decided locally.
module kms_scanner #(
  parameter int unsigned TICK_CYCLES = kms_pkg::KMS_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // Register port
  input  wire kms_pkg::kms_bus_req_type bus_req,
  output logic [7:0]                    bus_rdata,
  // Keypad matrix
  output logic [4:0]                    col_out,
  input  wire logic [5:0]               row_in,
  // Interrupt
  output logic                          irq
);
  import kms_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETTLE_PRESS, ST_PROBE, ST_WAIT_REL, ST_SETTLE_REL
  } kms_state_type;

  function automatic logic [5:0] kms_low_at(input logic [2:0] idx);
    return ~(6'h01 << idx);
  endfunction

  // ****************************************
  // Row synchroniser and 1 kHz tick
  // ****************************************
  logic [5:0]    row_meta;
  logic [5:0]    row_sync;
  logic          prev_all_high;
  logic [TW-1:0] tick_cnt;
  logic [TW-1:0] next_tick_cnt;
  logic          tick;
  logic          keyclk;
  logic          all_high;

  assign all_high = &row_sync;
  assign tick     = (tick_cnt == TW'(TICK_CYCLES - 1));

  always_comb
  begin
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      row_meta      <= KMS_SENSE_RST;
      row_sync      <= KMS_SENSE_RST;
      prev_all_high <= 1'b1;
      tick_cnt      <= '0;
      keyclk        <= 1'b0;
    end
    else
    begin
      row_meta      <= row_in;
      row_sync      <= row_meta;
      prev_all_high <= all_high;
      tick_cnt      <= next_tick_cnt;
      keyclk        <= (tick_cnt < TW'(TICK_CYCLES / 2));
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [4:0] drive_line_value;
  logic [5:0] sense_line_value;
  logic [7:0] keypad_timing;
  logic       auto_sweep_enable;
  logic [1:0] int_status;
  logic [1:0] int_en;
  logic [4:0] next_drive;
  logic [5:0] next_sense;
  logic [7:0] next_timing;
  logic       next_auto;
  logic [1:0] next_status;
  logic [1:0] next_en;
  logic [7:0] next_rdata;
  logic       key_evt;
  logic       multi_evt;
  logic       bypass_edge;
  logic [2:0] hit_col;
  logic [2:0] hit_row;
  logic [5:0] settle_code;
  logic [1:0] probe_code;
  logic [8:0] settle_ms;
  logic [8:0] probe_ms;

  assign settle_code = keypad_timing[KMS_SETTLE_LSB +: 6];
  assign probe_code  = keypad_timing[KMS_PROBE_LSB +: 2];
  assign settle_ms   = {(settle_code == 6'h00), settle_code, 2'b00};
  assign probe_ms    = {6'h00, (probe_code == 2'h0), probe_code};
  assign bypass_edge = !auto_sweep_enable && prev_all_high && !all_high;

  always_comb
  begin
    next_drive  = drive_line_value;
    next_sense  = sense_line_value;
    next_timing = keypad_timing;
    next_auto   = auto_sweep_enable;
    next_status = int_status;
    next_en     = int_en;
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        KMS_ADR_DRIVE:   next_drive = bus_req.wdata[4:0];
        KMS_ADR_TIMING:  next_timing = bus_req.wdata;
        KMS_ADR_CTRL:
        begin
          next_auto            = bus_req.wdata[KMS_CTL_AUTO];
          next_en[KMS_INT_KEY] = bus_req.wdata[KMS_CTL_EN];
        end
        KMS_ADR_INT_CLR: next_status = int_status & ~bus_req.wdata[1:0];
        KMS_ADR_INT_EN:  next_en = bus_req.wdata[1:0];
        default:         next_en = next_en;
      endcase
    end
    if (bus_req.rd && bus_req.addr == KMS_ADR_CTRL)
    begin
      next_status[KMS_INT_KEY] = 1'b0;
    end
    if (key_evt)
    begin
      next_drive = 5'(kms_low_at(hit_col));
      next_sense = kms_low_at(hit_row);
    end
    // Set wins over clear
    next_status[KMS_INT_KEY]   = next_status[KMS_INT_KEY] | key_evt | bypass_edge;
    next_status[KMS_INT_MULTI] = next_status[KMS_INT_MULTI] | multi_evt;
  end

  always_comb
  begin
    unique case (bus_req.addr)
      KMS_ADR_DRIVE:  next_rdata = {3'h0, drive_line_value};
      KMS_ADR_SENSE:  next_rdata = {2'h0, auto_sweep_enable ? sense_line_value : row_sync};
      KMS_ADR_TIMING: next_rdata = keypad_timing;
      KMS_ADR_CTRL:   next_rdata = {4'h0, keyclk, auto_sweep_enable,
                                    int_status[KMS_INT_KEY], int_en[KMS_INT_KEY]};
      KMS_ADR_INT_ST: next_rdata = {6'h00, int_status};
      KMS_ADR_INT_EN: next_rdata = {6'h00, int_en};
      default:        next_rdata = 8'h00;
    endcase
    if (!bus_req.rd)
    begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drive_line_value  <= KMS_DRIVE_RST;
      sense_line_value  <= KMS_SENSE_RST;
      keypad_timing     <= KMS_TIMING_RST;
      auto_sweep_enable <= 1'b0;
      int_status        <= 2'h0;
      int_en            <= 2'h0;
      bus_rdata         <= 8'h00;
      irq               <= 1'b0;
    end
    else
    begin
      drive_line_value  <= next_drive;
      sense_line_value  <= next_sense;
      keypad_timing     <= next_timing;
      auto_sweep_enable <= next_auto;
      int_status        <= next_status;
      int_en            <= next_en;
      bus_rdata         <= next_rdata;
      irq               <= |(next_status & next_en);
    end
  end

  // ****************************************
  // Sweep engine
  // ****************************************
  kms_state_type state;
  kms_state_type next_state;
  logic [8:0]    ms_left;
  logic [8:0]    next_ms_left;
  logic [2:0]    col_idx;
  logic [2:0]    next_col_idx;
  logic [2:0]    row_idx;
  logic [2:0]    next_row_idx;
  logic [1:0]    hits;
  logic [1:0]    next_hits;
  logic [2:0]    next_hit_col;
  logic [2:0]    next_hit_row;
  logic [4:0]    next_col_out;
  logic          expire;

  assign expire = tick && (ms_left == 9'h001);

  always_comb
  begin
    next_state   = state;
    next_ms_left = (tick && ms_left != 9'h000) ? ms_left - 1'b1 : ms_left;
    next_col_idx = col_idx;
    next_row_idx = row_idx;
    next_hits    = hits;
    next_hit_col = hit_col;
    next_hit_row = hit_row;
    key_evt      = 1'b0;
    multi_evt    = 1'b0;
    if (!auto_sweep_enable)
    begin
      next_state = ST_IDLE;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (!all_high)
          begin
            next_state   = ST_SETTLE_PRESS;
            next_ms_left = settle_ms;
          end
        end
        ST_SETTLE_PRESS:
        begin
          if (expire && all_high)
          begin
            next_state = ST_IDLE;
          end
          else if (expire)
          begin
            next_state   = ST_PROBE;
            next_ms_left = probe_ms;
            next_col_idx = 3'h0;
            next_row_idx = 3'h0;
            next_hits    = 2'h0;
          end
        end
        ST_PROBE:
        begin
          if (expire)
          begin
            next_ms_left = probe_ms;
            if (!row_sync[row_idx])
            begin
              next_hits    = (hits == 2'h2) ? hits : hits + 1'b1;
              next_hit_col = col_idx;
              next_hit_row = row_idx;
            end
            next_row_idx = row_idx + 1'b1;
            if (row_idx == 3'(KMS_ROWS - 1))
            begin
              next_row_idx = 3'h0;
              next_col_idx = col_idx + 1'b1;
              if (col_idx == 3'(KMS_COLS - 1))
              begin
                next_state = ST_WAIT_REL;
                key_evt    = (next_hits == 2'h1);
                multi_evt  = (next_hits != 2'h1);
              end
            end
          end
        end
        ST_WAIT_REL:
        begin
          if (all_high)
          begin
            next_state   = ST_SETTLE_REL;
            next_ms_left = settle_ms;
          end
        end
        ST_SETTLE_REL:
        begin
          if (expire)
          begin
            next_state = all_high ? ST_IDLE : ST_WAIT_REL;
          end
        end
      endcase
    end
    // Column drive follows the state being entered, or the drive register when the sweep is off
    if (!auto_sweep_enable)
    begin
      next_col_out = drive_line_value;
    end
    else if (next_state == ST_PROBE)
    begin
      next_col_out = 5'(kms_low_at(next_col_idx));
    end
    else
    begin
      next_col_out = 5'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state   <= ST_IDLE;
      ms_left <= 9'h000;
      col_idx <= 3'h0;
      row_idx <= 3'h0;
      hits    <= 2'h0;
      hit_col <= 3'h0;
      hit_row <= 3'h0;
      col_out <= KMS_DRIVE_RST;
    end
    else
    begin
      state   <= next_state;
      ms_left <= next_ms_left;
      col_idx <= next_col_idx;
      row_idx <= next_row_idx;
      hits    <= next_hits;
      hit_col <= next_hit_col;
      hit_row <= next_hit_row;
      col_out <= next_col_out;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_cols_bypass: assert property (!auto_sweep_enable |=>
    col_out == $past(drive_line_value)) else $error("columns differ from drive register");
  a_idle_all_low: assert property ($past(auto_sweep_enable) && state == ST_IDLE
    |-> col_out == 5'h00) else $error("idle columns not all low");
  a_probe_one_col: assert property (state == ST_PROBE
    |-> $countones(~col_out) == 1) else $error("probe drives not one column");
  a_settle_load: assert property (auto_sweep_enable && state == ST_IDLE && !all_high
    |=> ms_left == {($past(settle_code) == 6'h00), $past(settle_code), 2'b00})
    else $error("settle time loaded wrong");
  a_probe_load: assert property (auto_sweep_enable && state == ST_PROBE && expire
    |=> ms_left == ((probe_code == 2'h0) ? 9'h004 : {7'h00, probe_code}))
    else $error("probe time loaded wrong");
  a_single_only: assert property (key_evt |=>
    $countones(~drive_line_value) == 1 && int_status[KMS_INT_KEY]) else $error("bad key report");
  a_read_clears: assert property (bus_req.rd && bus_req.addr == KMS_ADR_CTRL
    && !key_evt && !bypass_edge |=> !int_status[KMS_INT_KEY]) else $error("flag not cleared");
  a_irq_gated: assert property (int_en == 2'h0 ##1 int_en == 2'h0
    |-> !irq) else $error("interrupt while disabled");
  a_rel_restart: assert property (auto_sweep_enable && state == ST_SETTLE_REL && expire
    && !all_high |=> state == ST_WAIT_REL) else $error("release settle did not restart");
  a_rel_done: assert property (auto_sweep_enable && state == ST_SETTLE_REL && expire
    && all_high |=> state == ST_IDLE ##1 col_out == 5'h00) else $error("columns not low again");

  c_valid_key: cover property (key_evt);
  c_multi_key: cover property (multi_evt);
  c_bypass_edge: cover property (bypass_edge);
  c_release: cover property (state == ST_SETTLE_REL ##1 state == ST_IDLE);

endmodule // kms_scanner

// ===== kms_scanner_tb_top.sv
// Self-checking bench of the keypad matrix scanner.
// Assumes kms_pkg, kms_scanner and kms_keypad_model are compiled first.
module kms_scanner_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import kms_pkg::*;
  localparam int T = 4;
  logic            clk_sys = 1'b0;
  logic            sys_rst = 1'b1;
  kms_bus_req_type bus_req = '0;
  logic [7:0]      bus_rdata;
  logic [4:0]      col_out;
  logic [5:0]      row_in;
  logic            irq;
  logic [29:0]     keys_down = '0;
  logic [5:0]      sc_tab [4] = '{6'h01, 6'h3f, 6'h00, 6'h02};
  logic [1:0]      pc_tab [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  int              err_total = 0;
  int              num_checks = 0;
  int              cyc = 0;
  int              n;
  int              sms;
  int              pm;

  kms_scanner #(.TICK_CYCLES(T)) kms_scanner_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .col_out(col_out), .row_in(row_in), .irq(irq));
  kms_keypad_model kms_keypad_model_inst (.col_out(col_out), .row_in(row_in),
    .keys_down(keys_down));

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                         input string what);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    check(what, bus_rdata & m, e);
  endtask

  task automatic set_keys(input logic [29:0] k);
    @(posedge clk_sys);
    keys_down <= k;
  endtask

  task automatic wait_col(input logic [4:0] v, output int cnt);
    cnt = 0;
    while (col_out !== v && cnt < 3000)
    begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
    check("col_out wait", col_out, v);
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check("irq raise", irq, 1'b1);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    #1;
    check("irq level", irq, e);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      complete_run();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    reg_chk(KMS_ADR_DRIVE, 8'hff, 8'h1f, "drive reset");
    reg_chk(KMS_ADR_SENSE, 8'hff, 8'h3f, "sense reset");
    reg_chk(KMS_ADR_TIMING, 8'hff, 8'h00, "timing reset");
    reg_chk(KMS_ADR_CTRL, 8'hf7, 8'h00, "control reset");
    check("col_out reset", col_out, 5'h1f);
    reg_wr(8'hd5, 8'h55);
    reg_chk(8'hd5, 8'hff, 8'h00, "unmapped read");
    reg_wr(KMS_ADR_DRIVE, 8'hff);
    reg_chk(KMS_ADR_DRIVE, 8'hff, 8'h1f, "drive width");
    $display("test registers done");

    // Bypass: firmware drives column 0 and judges rows itself
    reg_wr(KMS_ADR_DRIVE, 8'h1e);
    @(posedge clk_sys);
    #1;
    check("col_out bypass", col_out, 5'h1e);
    set_keys(30'h0000_0001);
    repeat (4) @(posedge clk_sys);
    reg_chk(KMS_ADR_SENSE, 8'hff, 8'h3e, "sense row0");
    check("irq masked", irq, 1'b0);
    reg_chk(KMS_ADR_INT_ST, 8'h01, 8'h01, "status key");
    reg_wr(KMS_ADR_INT_EN, 8'h01);
    irq_is(1'b1);
    reg_chk(KMS_ADR_CTRL, 8'h07, 8'h03, "flag set");
    irq_is(1'b0);
    reg_chk(KMS_ADR_CTRL, 8'h07, 8'h01, "flag cleared");
    set_keys(30'h0);
    repeat (4) @(posedge clk_sys);
    set_keys(30'h0000_0020);
    repeat (4) @(posedge clk_sys);
    reg_chk(KMS_ADR_SENSE, 8'hff, 8'h1f, "sense row5");
    irq_is(1'b1);
    reg_wr(KMS_ADR_INT_CLR, 8'h01);
    irq_is(1'b0);
    set_keys(30'h0);
    $display("test bypass done");

    // Sweep with four settle codes and each probe code, key at column 2 row 3
    reg_wr(KMS_ADR_INT_EN, 8'h03);
    reg_wr(KMS_ADR_CTRL, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      sms = (sc_tab[i] == 6'h00) ? 256 : 4 * sc_tab[i];
      pm = (pc_tab[i] == 2'h0) ? 4 : pc_tab[i];
      reg_wr(KMS_ADR_TIMING, {sc_tab[i], pc_tab[i]});
      wait_col(5'h00, n);
      set_keys(30'h0000_8000);
      wait_col(5'h1e, n);
      check("settle time", n >= (sms - 1) * T && n <= sms * T + 8, 1'b1);
      wait_col(5'h1d, n);
      wait_col(5'h1b, n);
      check("probe time", n >= (6 * pm - 1) * T && n <= 6 * pm * T + 2, 1'b1);
      wait_irq();
      reg_chk(KMS_ADR_DRIVE, 8'hff, 8'h1b, "key column");
      reg_chk(KMS_ADR_SENSE, 8'hff, 8'h37, "key row");
      reg_chk(KMS_ADR_INT_ST, 8'h03, 8'h01, "single key");
      reg_wr(KMS_ADR_INT_CLR, 8'h03);
      set_keys(30'h0);
      repeat ((sms + 2) * T + 8) @(posedge clk_sys);
      check("col_out release", col_out, 5'h00);
    end
    $display("test sweep done");

    // Two keys at once give no key, only the multi status
    reg_wr(KMS_ADR_TIMING, 8'h05);
    set_keys(30'h0000_0081);
    wait_irq();
    reg_chk(KMS_ADR_INT_ST, 8'h03, 8'h02, "multi key");
    reg_chk(KMS_ADR_DRIVE, 8'hff, 8'h1b, "drive kept");
    reg_wr(KMS_ADR_INT_CLR, 8'h03);
    set_keys(30'h0);
    // Release settle must end before the next press arrives
    repeat (6 * T + 8) @(posedge clk_sys);
    check("col_out after multi", col_out, 5'h00);

    // Sweep stopped mid-scan hands columns back to the drive register
    set_keys(30'h0000_8000);
    wait_col(5'h1d, n);
    reg_wr(KMS_ADR_CTRL, 8'h01);
    @(posedge clk_sys);
    #1;
    check("col_out stopped", col_out, 5'h1b);
    set_keys(30'h0);
    $display("test multi and stop done");
    complete_run();
  end
endmodule // kms_scanner_tb_top
